/* verilog/sync_router_pkg.sv */
package sync_router_pkg;

  // ----------------------------------------------------------------
  // line layout
  // ----------------------------------------------------------------
  localparam int NUM_LINES = 6;
  localparam int LINE_TIMEBASE = 0;
  localparam int LINE_ACQ_TRIGGER = 1;
  localparam int LINE_CONVERT_STROBE = 2;
  localparam int LINE_SCAN_BEGIN = 3;
  localparam int LINE_OUTPUT_TRIGGER = 4;
  localparam int LINE_OUTPUT_UPDATE = 5;

  // ----------------------------------------------------------------
  // role encoding, two bits per line
  // ----------------------------------------------------------------
  localparam int ROLE_W = 2;
  localparam logic [1:0] ROLE_DISABLED = 2'h0;
  localparam logic [1:0] ROLE_MASTER = 2'h1;
  localparam logic [1:0] ROLE_SLAVE = 2'h2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [NUM_LINES*ROLE_W-1:0] ROLES_RESET = 12'h000;
  localparam logic [NUM_LINES-1:0] LINES_RESET = 6'h00;

endpackage

/* verilog/bus_line_if.sv */
`timescale 1ns/1ps
interface bus_line_if;
  // all signals live in the link clock domain
  logic drive_val;
  logic drive_en;
  logic use_backplane;
  logic rx_val;

  modport core
  (
    output drive_val,
    output drive_en,
    output use_backplane,
    input rx_val
  );

  modport port
  (
    input drive_val,
    input drive_en,
    input use_backplane,
    output rx_val
  );
endinterface

/* verilog/level_sync.sv */
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 1
)
(
  // clock and reset of the receiving domain
  input wire logic clk_in,
  input wire logic rst_in,
  // level from the other domain
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_q <= '0;
      q_out <= '0;
    end
    else
    begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end

endmodule

/* verilog/bus_line_port.sv */
`timescale 1ns/1ps
module bus_line_port
(
  // link clock domain
  input wire logic link_clk_in,
  input wire logic link_rst_in,
  // core side
  bus_line_if.port line,
  // ribbon connector pin
  input wire logic ribbon_in,
  output logic ribbon_out,
  output logic ribbon_oe_out,
  // backplane trigger pin
  input wire logic backplane_in,
  output logic backplane_out,
  output logic backplane_oe_out
);

  logic [1:0] pins_sync;

  // -------------------------------------------------------------
  // receive: each pin synchronised before the connector select
  // -------------------------------------------------------------
  level_sync #(.W(2)) u_pin_sync
  (
    .clk_in(link_clk_in),
    .rst_in(link_rst_in),
    .d_in({backplane_in, ribbon_in}),
    .q_out(pins_sync)
  );

  always_ff @(posedge link_clk_in)
  begin
    if (link_rst_in)
      line.rx_val <= 1'b0;
    else
      line.rx_val <= line.use_backplane ? pins_sync[1] : pins_sync[0];
  end

  // -------------------------------------------------------------
  // drive: enable only for the master on the selected connector
  // -------------------------------------------------------------
  always_ff @(posedge link_clk_in)
  begin
    if (link_rst_in)
    begin
      ribbon_out <= 1'b0;
      backplane_out <= 1'b0;
      ribbon_oe_out <= 1'b0;
      backplane_oe_out <= 1'b0;
    end
    else
    begin
      ribbon_out <= line.drive_val;
      backplane_out <= line.drive_val;
      ribbon_oe_out <= line.drive_en & ~line.use_backplane;
      backplane_oe_out <= line.drive_en & line.use_backplane;
    end
  end

endmodule

/* verilog/card_sync_timing_router.sv */
// Functional notes
// - one master, up to three slaves per line
// - timebase: master drives, slave substitutes received
// - acq trigger: master drives, slave uses received
// - convert strobe: master drives, slave substitutes received
// - scan begin: master drives, slave substitutes received
// - output trigger: master drives, slave uses received
// - update strobe: master drives, slave substitutes received
// - role chosen independently for every line
// - all lines routed together to ribbon or backplane
// - reset restores internal sources everywhere
// - master strobe used locally and driven together
// - started operations stay armed until trigger
// - scan begin sampled on active timebase
`timescale 1ns/1ps
module card_sync_timing_router
(
  // system clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // link clock of the sync bus
  input wire logic bus_clk_in,
  // configuration
  input wire logic [11:0] line_role_in,
  input wire logic route_backplane_in,
  // internally generated timing signals
  input wire logic int_timebase_in,
  input wire logic int_acq_trigger_in,
  input wire logic int_convert_strobe_in,
  input wire logic int_scan_begin_in,
  input wire logic int_output_trigger_in,
  input wire logic int_output_update_strobe_in,
  // operation start requests
  input wire logic acq_arm_in,
  input wire logic out_arm_in,
  // ribbon connector lines
  input wire logic [5:0] ribbon_in,
  output logic [5:0] ribbon_out,
  output logic [5:0] ribbon_oe_out,
  // backplane trigger lines
  input wire logic [5:0] backplane_in,
  output logic [5:0] backplane_out,
  output logic [5:0] backplane_oe_out,
  // effective timing signals
  output logic timebase_out,
  output logic acq_trigger_out,
  output logic convert_strobe_out,
  output logic scan_begin_out,
  output logic output_trigger_out,
  output logic output_update_strobe_out,
  // edge events
  output logic convert_pulse_out,
  output logic update_pulse_out,
  output logic acq_start_out,
  output logic out_start_out,
  // status
  output logic acq_armed_out,
  output logic out_armed_out,
  output logic [5:0] line_master_out,
  output logic [5:0] line_slave_out
);

  localparam int N = sync_router_pkg::NUM_LINES;
  localparam int RW = sync_router_pkg::ROLE_W;

  // ----------------------------------------------------------------
  // role decoding
  // ----------------------------------------------------------------
  function automatic logic role_is(input logic [11:0] roles, input int idx, input logic [1:0] code);
    role_is = (roles[idx*RW +: RW] == code);
  endfunction

  logic [11:0] role_q;
  logic route_q;
  logic [N-1:0] master_q;
  logic [N-1:0] slave_q;

  // roles fall back to disabled, so every line uses its internal source
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      role_q <= sync_router_pkg::ROLES_RESET;
      route_q <= 1'b0;
    end
    else
    begin
      role_q <= line_role_in;
      route_q <= route_backplane_in;
    end
  end

  // an unknown role code is treated as disabled
  generate
    for (genvar r = 0; r < N; r++)
    begin : g_role
      always_ff @(posedge clock_in)
      begin
        if (sys_rst_in)
        begin
          master_q[r] <= 1'b0;
          slave_q[r] <= 1'b0;
        end
        else
        begin
          master_q[r] <= role_is(role_q, r, sync_router_pkg::ROLE_MASTER);
          slave_q[r] <= role_is(role_q, r, sync_router_pkg::ROLE_SLAVE);
        end
      end
    end
  endgenerate

  assign line_master_out = master_q;
  assign line_slave_out = slave_q;

  // ----------------------------------------------------------------
  // internal sources
  // ----------------------------------------------------------------
  logic [N-1:0] int_vec;

  always_comb
  begin
    int_vec = sync_router_pkg::LINES_RESET;
    int_vec[sync_router_pkg::LINE_TIMEBASE] = int_timebase_in;
    int_vec[sync_router_pkg::LINE_ACQ_TRIGGER] = int_acq_trigger_in;
    int_vec[sync_router_pkg::LINE_CONVERT_STROBE] = int_convert_strobe_in;
    int_vec[sync_router_pkg::LINE_SCAN_BEGIN] = int_scan_begin_in;
    int_vec[sync_router_pkg::LINE_OUTPUT_TRIGGER] = int_output_trigger_in;
    int_vec[sync_router_pkg::LINE_OUTPUT_UPDATE] = int_output_update_strobe_in;
  end

  // ----------------------------------------------------------------
  // transmit levels, system side
  // ----------------------------------------------------------------
  logic [N-1:0] tx_q;

  // master sends its own source; others hold the line low internally
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      tx_q <= sync_router_pkg::LINES_RESET;
    else
      tx_q <= int_vec & master_q;
  end

  // ----------------------------------------------------------------
  // link domain reset and crossings
  // ----------------------------------------------------------------
  logic link_rst;
  logic [N-1:0] tx_link;
  logic [N-1:0] en_link;
  logic route_link;
  logic [N-1:0] rx_link;
  logic [N-1:0] rx_sys;

  level_sync #(.W(1)) u_link_rst
  (
    .clk_in(bus_clk_in),
    .rst_in(1'b0),
    .d_in(sys_rst_in),
    .q_out(link_rst)
  );

  // slow link clock: bus strobes must last a few link periods
  level_sync #(.W(2*N+1)) u_to_link
  (
    .clk_in(bus_clk_in),
    .rst_in(link_rst),
    .d_in({route_q, master_q, tx_q}),
    .q_out({route_link, en_link, tx_link})
  );

  level_sync #(.W(N)) u_to_sys
  (
    .clk_in(clock_in),
    .rst_in(sys_rst_in),
    .d_in(rx_link),
    .q_out(rx_sys)
  );

  // ----------------------------------------------------------------
  // bus pins, one port per line
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < N; i++)
    begin : g_line
      bus_line_if lif();

      assign lif.drive_val = tx_link[i];
      assign lif.drive_en = en_link[i];
      assign lif.use_backplane = route_link;
      assign rx_link[i] = lif.rx_val;

      bus_line_port u_port
      (
        .link_clk_in(bus_clk_in),
        .link_rst_in(link_rst),
        .line(lif.port),
        .ribbon_in(ribbon_in[i]),
        .ribbon_out(ribbon_out[i]),
        .ribbon_oe_out(ribbon_oe_out[i]),
        .backplane_in(backplane_in[i]),
        .backplane_out(backplane_out[i]),
        .backplane_oe_out(backplane_oe_out[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  logic [N-1:0] eff_q;

  // slave takes the bus, master and disabled keep internal
  generate
    for (genvar s = 0; s < N; s++)
    begin : g_sel
      always_ff @(posedge clock_in)
      begin
        if (sys_rst_in)
          eff_q[s] <= 1'b0;
        else
          eff_q[s] <= slave_q[s] ? rx_sys[s] : int_vec[s];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // scan begin on the active timebase
  // ----------------------------------------------------------------
  logic [N-1:0] prev_q;
  logic [N-1:0] rise;
  logic scan_q;
  logic tb_rise;

  // one delayed copy of every effective line feeds all the edge detectors
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      prev_q <= sync_router_pkg::LINES_RESET;
    else
      prev_q <= eff_q;
  end

  assign rise = eff_q & ~prev_q;
  assign tb_rise = rise[sync_router_pkg::LINE_TIMEBASE];

  // keeps scan begin aligned whichever card supplies the timebase
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      scan_q <= 1'b0;
    else if (tb_rise)
      scan_q <= eff_q[sync_router_pkg::LINE_SCAN_BEGIN];
  end

  // ----------------------------------------------------------------
  // edge detection on strobes and triggers
  // ----------------------------------------------------------------
  logic acq_rise;
  logic outt_rise;

  assign acq_rise = rise[sync_router_pkg::LINE_ACQ_TRIGGER];
  assign outt_rise = rise[sync_router_pkg::LINE_OUTPUT_TRIGGER];

  // strobes are rising-edge sensitive
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      convert_pulse_out <= 1'b0;
      update_pulse_out <= 1'b0;
    end
    else
    begin
      convert_pulse_out <= rise[sync_router_pkg::LINE_CONVERT_STROBE];
      update_pulse_out <= rise[sync_router_pkg::LINE_OUTPUT_UPDATE];
    end
  end

  // ----------------------------------------------------------------
  // arming
  // ----------------------------------------------------------------
  logic acq_armed_q;
  logic out_armed_q;

  // a trigger edge only starts an operation that is already armed
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      acq_armed_q <= 1'b0;
    else if (acq_armed_q && acq_rise)
      acq_armed_q <= 1'b0;
    else if (acq_arm_in)
      acq_armed_q <= 1'b1;
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      out_armed_q <= 1'b0;
    else if (out_armed_q && outt_rise)
      out_armed_q <= 1'b0;
    else if (out_arm_in)
      out_armed_q <= 1'b1;
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      acq_start_out <= 1'b0;
      out_start_out <= 1'b0;
    end
    else
    begin
      acq_start_out <= acq_armed_q & acq_rise;
      out_start_out <= out_armed_q & outt_rise;
    end
  end

  assign acq_armed_out = acq_armed_q;
  assign out_armed_out = out_armed_q;

  // ----------------------------------------------------------------
  // effective signal outputs
  // ----------------------------------------------------------------
  assign timebase_out = eff_q[sync_router_pkg::LINE_TIMEBASE];
  assign acq_trigger_out = eff_q[sync_router_pkg::LINE_ACQ_TRIGGER];
  assign convert_strobe_out = eff_q[sync_router_pkg::LINE_CONVERT_STROBE];
  assign scan_begin_out = scan_q;
  assign output_trigger_out = eff_q[sync_router_pkg::LINE_OUTPUT_TRIGGER];
  assign output_update_strobe_out = eff_q[sync_router_pkg::LINE_OUTPUT_UPDATE];

endmodule

/* test/sync_router_props.sv */
`timescale 1ns/1ps
// ----------------------------------------
// router checker
// ----------------------------------------
module sync_router_props
(
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // requests
  input wire logic [11:0] line_role_in,
  input wire logic acq_arm_in,
  input wire logic out_arm_in,
  // outputs
  input wire logic [5:0] ribbon_oe_out,
  input wire logic [5:0] backplane_oe_out,
  input wire logic timebase_out,
  input wire logic scan_begin_out,
  input wire logic convert_strobe_out,
  input wire logic output_update_strobe_out,
  input wire logic convert_pulse_out,
  input wire logic update_pulse_out,
  input wire logic acq_start_out,
  input wire logic out_start_out,
  input wire logic acq_armed_out,
  input wire logic out_armed_out,
  input wire logic [5:0] line_master_out,
  input wire logic [5:0] line_slave_out
);
  logic [5:0] m_dec;
  logic [5:0] s_dec;
  logic [6:0] idle_q;
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      m_dec[i] = line_role_in[2*i +: 2] == sync_router_pkg::ROLE_MASTER;
      s_dec[i] = line_role_in[2*i +: 2] == sync_router_pkg::ROLE_SLAVE;
    end
  end
  // oe crosses into the link domain, so allow it many cycles to drop
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in || line_master_out != 6'h00)
      idle_q <= 7'h00;
    else if (idle_q != 7'h7F)
      idle_q <= idle_q + 7'h01;
  end
  sequence conv_rise_s;
    !convert_strobe_out ##1 convert_strobe_out;
  endsequence
  sequence upd_rise_s;
    !output_update_strobe_out ##1 output_update_strobe_out;
  endsequence
  reset_clears_a: assert property (disable iff (1'b0) sys_rst_in |=>
    line_master_out == 6'h00 && line_slave_out == 6'h00 && !acq_armed_out && !out_armed_out && !acq_start_out)
    else $error("state not cleared by reset");
  role_decode_a: assert property (!$past(sys_rst_in) && !$past(sys_rst_in, 2) |->
    line_master_out == $past(m_dec, 2) && line_slave_out == $past(s_dec, 2))
    else $error("role status does not follow role request");
  role_excl_a: assert property ((line_master_out & line_slave_out) == 6'h00)
    else $error("line both master and slave");
  one_connector_a: assert property ((ribbon_oe_out & backplane_oe_out) == 6'h00)
    else $error("both connectors driven");
  idle_quiet_a: assert property (idle_q >= 7'h40 |-> (ribbon_oe_out | backplane_oe_out) == 6'h00)
    else $error("line driven without master role");
  acq_start_a: assert property (acq_start_out |-> $past(acq_armed_out) && !acq_armed_out)
    else $error("acq start without arm");
  out_start_a: assert property (out_start_out |-> $past(out_armed_out) && !out_armed_out)
    else $error("out start without arm");
  acq_arm_a: assert property ($rose(acq_armed_out) |-> $past(acq_arm_in))
    else $error("acq armed without request");
  arm_hold_a: assert property ($fell(acq_armed_out) |-> acq_start_out)
    else $error("acq armed dropped without start");
  conv_pulse_a: assert property (conv_rise_s |=> convert_pulse_out)
    else $error("no convert pulse");
  upd_pulse_a: assert property (upd_rise_s |=> update_pulse_out)
    else $error("no update pulse");
  scan_on_tb_a: assert property ($changed(scan_begin_out) |-> timebase_out || $past(timebase_out))
    else $error("scan begin moved off timebase");
endmodule
bind card_sync_timing_router sync_router_props chk
(
  .clock_in, .sys_rst_in, .line_role_in, .acq_arm_in, .out_arm_in, .ribbon_oe_out, .backplane_oe_out,
  .timebase_out, .scan_begin_out, .convert_strobe_out, .output_update_strobe_out, .convert_pulse_out,
  .update_pulse_out, .acq_start_out, .out_start_out, .acq_armed_out, .out_armed_out, .line_master_out,
  .line_slave_out
);

/* test/sync_bus_partner.sv */
`timescale 1ns/1ps
// ----------------------------------------
// other cards on the bus
// ----------------------------------------
module sync_bus_partner
(
  // link clock and other masters
  input wire logic bus_clk_in,
  input wire logic route_backplane_in,
  input wire logic [5:0] drive_mask_in,
  input wire logic [5:0] drive_val_in,
  // card under test
  input wire logic [5:0] ribbon_out_in,
  input wire logic [5:0] ribbon_oe_in,
  input wire logic [5:0] backplane_out_in,
  input wire logic [5:0] backplane_oe_in,
  // resolved levels
  output logic [5:0] ribbon_level_out,
  output logic [5:0] backplane_level_out,
  output logic clash_out
);
  logic [5:0] tx_q = 6'h00;
  logic [5:0] noise_q = 6'h15;
  logic [5:0] rib_drv;
  logic [5:0] bp_drv;
  // undriven lines wander, so a stale level never reads as data
  always @(posedge bus_clk_in)
  begin
    noise_q <= ~noise_q;
    tx_q <= drive_val_in;
  end
  // only the routed connector carries a sibling master
  assign rib_drv = route_backplane_in ? 6'h00 : drive_mask_in;
  assign bp_drv = route_backplane_in ? drive_mask_in : 6'h00;
  assign ribbon_level_out = (ribbon_oe_in & ribbon_out_in)
    | (~ribbon_oe_in & ((rib_drv & tx_q) | (~rib_drv & noise_q)));
  assign backplane_level_out = (backplane_oe_in & backplane_out_in)
    | (~backplane_oe_in & ((bp_drv & tx_q) | (~bp_drv & noise_q)));
  // two masters on one line
  assign clash_out = |((ribbon_oe_in & rib_drv) | (backplane_oe_in & bp_drv));
endmodule

/* test/card_sync_timing_router_tb_top.sv */
`timescale 1ns/1ps
module card_sync_timing_router_tb_top;
  logic clock_in = 1'b0;
  logic bus_clk = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [11:0] role = 12'h000;
  logic route = 1'b0;
  logic [5:0] int_v = 6'h00;
  logic [5:0] pval = 6'h00;
  logic [5:0] pmask = 6'h00;
  logic [1:0] arm = 2'h0;
  logic [7:0] seed = 8'h50;
  logic [5:0] rib_lvl, bp_lvl, rib_o, rib_oe, bp_o, bp_oe, mst, slv, eff;
  logic [1:0] armed, start, pulse;
  logic clash;
  int err_total = 0;
  int compares = 0;
  always #2.5 clock_in = ~clock_in;
  always #16 bus_clk = ~bus_clk;
  card_sync_timing_router uut
  (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .bus_clk_in(bus_clk), .line_role_in(role),
    .route_backplane_in(route), .int_timebase_in(int_v[0]), .int_acq_trigger_in(int_v[1]),
    .int_convert_strobe_in(int_v[2]), .int_scan_begin_in(int_v[3]), .int_output_trigger_in(int_v[4]),
    .int_output_update_strobe_in(int_v[5]), .acq_arm_in(arm[0]), .out_arm_in(arm[1]),
    .ribbon_in(rib_lvl), .ribbon_out(rib_o), .ribbon_oe_out(rib_oe), .backplane_in(bp_lvl),
    .backplane_out(bp_o), .backplane_oe_out(bp_oe), .timebase_out(eff[0]), .acq_trigger_out(eff[1]),
    .convert_strobe_out(eff[2]), .scan_begin_out(eff[3]), .output_trigger_out(eff[4]),
    .output_update_strobe_out(eff[5]), .convert_pulse_out(pulse[0]), .update_pulse_out(pulse[1]),
    .acq_start_out(start[0]), .out_start_out(start[1]), .acq_armed_out(armed[0]),
    .out_armed_out(armed[1]), .line_master_out(mst), .line_slave_out(slv)
  );
  sync_bus_partner peer
  (
    .bus_clk_in(bus_clk), .route_backplane_in(route), .drive_mask_in(pmask), .drive_val_in(pval),
    .ribbon_out_in(rib_o), .ribbon_oe_in(rib_oe), .backplane_out_in(bp_o), .backplane_oe_in(bp_oe),
    .ribbon_level_out(rib_lvl), .backplane_level_out(bp_lvl), .clash_out(clash)
  );
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cmp6(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic report_and_stop();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // held in link cycles: the link reset needs several bus clock edges
  task automatic do_reset();
    sys_rst_in = 1'b1;
    repeat (8) @(posedge bus_clk);
    tick(1);
    cmp6(mst | slv, 6'h00);
    cmp6(rib_oe | bp_oe, 6'h00);
    cmp6({4'h0, armed}, 6'h00);
    sys_rst_in = 1'b0;
    tick(2);
    $display("reset test done");
  endtask
  task automatic run_routing(input int n);
    logic [5:0] m;
    logic [5:0] s;
    for (int k = 0; k < n; k++)
    begin
      seed = lfsr(seed);
      role[11:4] = seed;
      seed = lfsr(seed);
      role[3:0] = seed[3:0];
      route = seed[4];
      int_v = seed[5:0] & 6'h3E;
      seed = lfsr(seed);
      pval = seed[5:0] & 6'h3E;
      for (int i = 0; i < 6; i++)
      begin
        m[i] = role[2*i +: 2] == sync_router_pkg::ROLE_MASTER;
        s[i] = role[2*i +: 2] == sync_router_pkg::ROLE_SLAVE;
      end
      pmask = ~m;
      tick(80);
      int_v[0] = 1'b1;
      pval[0] = 1'b1;
      tick(80);
      cmp6(mst, m);
      cmp6(slv, s);
      cmp6(eff, (s & pval) | (~s & int_v));
      cmp6(rib_oe, route ? 6'h00 : m);
      cmp6(bp_oe, route ? m : 6'h00);
      cmp6((route ? bp_o : rib_o) & m, m & int_v);
      cmp6({5'h00, clash}, 6'h00);
      $display("routing test %0d done", k);
    end
  endtask
  // each rising strobe edge must give exactly one pulse, never more
  task automatic run_strobe();
    int npc;
    int npu;
    role = 12'h000;
    int_v = 6'h00;
    tick(80);
    npc = 0;
    npu = 0;
    int_v[2] = 1'b1;
    int_v[5] = 1'b1;
    repeat (10)
    begin
      tick(1);
      npc += pulse[0];
      npu += pulse[1];
    end
    cmp6(npc[5:0], 6'h01);
    cmp6(npu[5:0], 6'h01);
    $display("strobe test done");
  endtask
  task automatic run_arm();
    int w;
    logic hit;
    role = 12'h000;
    int_v = 6'h00;
    tick(80);
    for (int k = 0; k < 2; k++)
    begin
      int_v = 6'h00;
      arm[k] = 1'b1;
      tick(1);
      arm[k] = 1'b0;
      tick(10);
      cmp6({4'h0, armed}, k ? 6'h02 : 6'h01);
      int_v[k ? 4 : 1] = 1'b1;
      w = 0;
      while (start[k] !== 1'b1 && w < 20)
      begin
        tick(1);
        w++;
      end
      cmp6({5'h00, start[k]}, 6'h01);
      tick(1);
      cmp6({4'h0, armed}, 6'h00);
      int_v = 6'h00;
      tick(10);
      int_v[k ? 4 : 1] = 1'b1;
      hit = 1'b0;
      repeat (15)
      begin
        tick(1);
        hit = hit | start[k];
      end
      cmp6({5'h00, hit}, 6'h00);
      $display("arm test %0d done", k);
    end
  endtask
  initial
  begin
    do_reset();
    run_routing(12);
    do_reset();
    run_routing(2);
    run_strobe();
    run_arm();
    report_and_stop();
  end
  // the tests need about 13 us; over twenty times that means a hang
  initial
  begin
    #300000;
    err_total++;
    report_and_stop();
  end
endmodule
